/* verilog/hmd_params.svh */
// Constants of the Hamming decoder pair: offsets, fields and reset values.
// Overview of operation
// - 8/4 decode starts only on register write
// - 16-bit register decodes two bytes per write
// - 8/4 read returns nibbles plus error flags
// - Single error is corrected and flagged
// - Double error gives flags only, no data
// - 24/18 decode runs on its high register writes
// - 24/18 read returns result, not coded data
// - Chained mode decodes back-to-back 24-bit words
// - Chain: low/high write gives first word
// - Chain: 8/4 write completes second word
`ifndef HMD_PARAMS_SVH
`define HMD_PARAMS_SVH
// Register word indices; the byte address is four times the index.
`define HMD_IDX_H84 12'h21a
`define HMD_IDX_LO 12'h21c
`define HMD_IDX_HI 12'h21e
`define HMD_IDX_CTRL 12'h220
`define HMD_IDX_STAT 12'h221
`define HMD_IDX_MASK 12'h222
// Result fields: data in the low bits, flags above.
`define HMD_F84_SGL 4
`define HMD_F84_DBL 5
`define HMD_FHI_SGL 4
`define HMD_FHI_DBL 5
// Control bit that selects chained decoding.
`define HMD_CTRL_CONT 0
// Event bits of the status and mask registers.
`define HMD_EV_SGL 0
`define HMD_EV_DBL 1
`define HMD_EV_DONE 2
// Reset values.
`define HMD_RST_WORD 16'h0000
`define HMD_RST_EV 3'h0
`endif

/* verilog/hmd_pkg.sv */
// Types shared by the Hamming decoder pair.
package hmd_pkg;
    // Bus slave phase, Gray coded.
    typedef enum logic [0:0] {
        HMD_ST_IDLE = 1'b0,
        HMD_ST_RWAIT = 1'b1
    } hmd_bus_st_t;
    // Width of one 8/4 result byte.
    typedef logic [7:0] hmd_res8_t;
endpackage : hmd_pkg

/* verilog/hmd_dec84.sv */
// One 8/4 Hamming byte decoder, purely combinational.
module hmd_dec84 (
    // Coded byte.
    input wire logic [7:0] code_i,
    // Decoded nibble and error flags.
    output logic [3:0] data_o,
    output logic single_o,
    output logic double_o
);
    logic [2:0] syn; // Failed parity checks.
    logic par_bad; // Overall odd parity failed.
    logic [7:0] fix; // Byte after correction.
    logic [2:0] pos; // Bit that the syndrome points at.

    // Checks use odd parity; a failed overall check means one flipped bit.
    always_comb begin
        syn[0] = ~(code_i[0] ^ code_i[1] ^ code_i[5] ^ code_i[7]);
        syn[1] = ~(code_i[1] ^ code_i[2] ^ code_i[3] ^ code_i[7]);
        syn[2] = ~(code_i[1] ^ code_i[3] ^ code_i[4] ^ code_i[5]);
        par_bad = ~(^code_i);
        unique case (syn)
            3'h0: pos = 3'h6;
            3'h1: pos = 3'h0;
            3'h2: pos = 3'h2;
            3'h3: pos = 3'h7;
            3'h4: pos = 3'h4;
            3'h5: pos = 3'h5;
            3'h6: pos = 3'h3;
            3'h7: pos = 3'h1;
        endcase
        fix = code_i;
        if (par_bad) begin
            fix[pos] = ~code_i[pos];
        end
        single_o = par_bad;
        double_o = ~par_bad & (syn != 3'h0);
        // A double error yields no data.
        data_o = double_o ? 4'h0 : {fix[7], fix[5], fix[3], fix[1]};
    end
endmodule : hmd_dec84

/* verilog/hmd_dec2418.sv */
// One 24/18 Hamming word decoder, purely combinational.
module hmd_dec2418 (
    // Coded word, bit 0 is position 1.
    input wire logic [23:0] code_i,
    // Decoded data and error flags.
    output logic [17:0] data_o,
    output logic single_o,
    output logic double_o
);
    logic [4:0] syn; // Position syndrome.
    logic par_bad; // Overall odd parity failed.
    logic [23:0] fix; // Word after correction.

    // Syndrome is the XOR of the positions of set bits 1..23.
    always_comb begin
        int k;
        k = 0;
        syn = 5'h00;
        for (int i = 0; i < 23; i++) begin
            if (code_i[i]) begin
                syn = syn ^ 5'(i + 1);
            end
        end
        par_bad = ~(^code_i);
        double_o = (syn != 5'h00) & (~par_bad | (syn > 5'd23));
        single_o = par_bad & ~double_o;
        fix = code_i;
        if (single_o && syn != 5'h00) begin
            fix[syn - 5'h01] = ~code_i[syn - 5'h01];
        end
        data_o = 18'h00000;
        for (int i = 0; i < 23; i++) begin
            if (((i + 1) & i) != 0) begin
                data_o[k] = fix[i];
                k = k + 1;
            end
        end
        if (double_o) begin
            data_o = 18'h00000;
        end
    end
endmodule : hmd_dec2418

/* verilog/hmd_top.sv */
// AHB-Lite Hamming decoder pair with chained 24/18 mode and interrupt.
`include "hmd_params.svh"
module hmd_top (
    // Clock and reset.
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    // AHB-Lite slave request.
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    // AHB-Lite slave answer.
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    // Interrupt.
    output logic IRQ_O
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations.
    ////////////////////////////////////////////////////////////////////////
    hmd_pkg::hmd_bus_st_t bus_st_ff; // Bus phase.
    logic acc; // Transfer accepted this cycle.
    logic hit; // Address is word aligned and in range.
    logic [11:0] idx; // Word index of the address phase.
    logic wr_ph_ff; // Write data phase pending.
    logic [11:0] wr_idx_ff; // Index of the pending write.
    logic [11:0] rd_idx_ff; // Index of the pending read.
    logic hready_ff; // Ready answer to the bus.
    logic [31:0] hrdata_ff; // Read data answer.
    logic hresp_ff; // Response, always OKAY.
    logic wr_84; // Write to the 8/4 register.
    logic wr_lo; // Write to the low 24/18 register.
    logic wr_hi; // Write to the high 24/18 register.
    logic wr_ctrl; // Write to the control register.
    logic wr_stat; // Write to the status register.
    logic wr_mask; // Write to the mask register.
    logic do_84; // Standalone 8/4 decode now.
    logic do_2418; // 24/18 decode now.
    logic cont_ff; // Chained mode enable.
    logic [15:0] coded_lo_ff; // Low coded half of the first word.
    logic [7:0] l2_ff; // Low byte of the next chained word.
    logic [15:0] res84_ff; // 8/4 result register.
    logic [15:0] nxt_res84; // Fresh 8/4 result.
    logic [1:0] sgl84; // Per-byte single error.
    logic [1:0] dbl84; // Per-byte double error.
    logic [23:0] in_2418; // Coded word into the 24/18 decoder.
    logic [17:0] d2418; // Decoded 24/18 data.
    logic s2418; // 24/18 single error.
    logic b2418; // 24/18 double error.
    logic [15:0] res_lo_ff; // 24/18 low result register.
    logic [15:0] res_hi_ff; // 24/18 high result register.
    logic [2:0] ev; // Events of this cycle.
    logic [2:0] stat_ff; // Sticky event status.
    logic [2:0] nxt_stat; // Next status.
    logic [2:0] mask_ff; // Interrupt mask.
    logic irq_ff; // Interrupt level.
    logic [31:0] rd_mux; // Read value selected by index.

    ////////////////////////////////////////////////////////////////////////
    // Address phase decode.
    ////////////////////////////////////////////////////////////////////////
    // Only NONSEQ or SEQ with ready high is taken.
    assign acc = HSEL_I & HTRANS_I[1] & HREADY_I;
    assign idx = HADDR_I[13:2];
    assign hit = (HADDR_I[31:14] == 18'h00000) & (HADDR_I[1:0] == 2'h0);

    // Write data phase decode; unmapped writes are dropped.
    assign wr_84 = wr_ph_ff & (wr_idx_ff == `HMD_IDX_H84);
    assign wr_lo = wr_ph_ff & (wr_idx_ff == `HMD_IDX_LO);
    assign wr_hi = wr_ph_ff & (wr_idx_ff == `HMD_IDX_HI);
    assign wr_ctrl = wr_ph_ff & (wr_idx_ff == `HMD_IDX_CTRL);
    assign wr_stat = wr_ph_ff & (wr_idx_ff == `HMD_IDX_STAT);
    assign wr_mask = wr_ph_ff & (wr_idx_ff == `HMD_IDX_MASK);

    // A chained 8/4 write feeds the 24/18 path and leaves the 8/4 result alone.
    assign do_84 = wr_84 & ~cont_ff;
    assign do_2418 = wr_hi | (wr_84 & cont_ff);

    // Remember the write target for its data phase.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            wr_ph_ff <= 1'b0;
            wr_idx_ff <= 12'h000;
        end else begin
            wr_ph_ff <= acc & HWRITE_I & hit;
            wr_idx_ff <= idx;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path: one wait state so that read data come from a register.
    ////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped words read zero.
    always_comb begin
        rd_mux = 32'h00000000;
        unique case (rd_idx_ff)
            `HMD_IDX_H84: rd_mux = {16'h0000, res84_ff};
            `HMD_IDX_LO: rd_mux = {16'h0000, res_lo_ff};
            `HMD_IDX_HI: rd_mux = {16'h0000, res_hi_ff};
            `HMD_IDX_CTRL: rd_mux = {31'h00000000, cont_ff};
            `HMD_IDX_STAT: rd_mux = {29'h00000000, stat_ff};
            `HMD_IDX_MASK: rd_mux = {29'h00000000, mask_ff};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Phase machine: a read drops ready for one cycle while data load.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            bus_st_ff <= hmd_pkg::HMD_ST_IDLE;
            hready_ff <= 1'b1;
            rd_idx_ff <= 12'hfff;
            hrdata_ff <= 32'h00000000;
        end else begin
            unique case (bus_st_ff)
                hmd_pkg::HMD_ST_IDLE: begin
                    // Start a read wait on an accepted read.
                    if (acc && !HWRITE_I) begin
                        bus_st_ff <= hmd_pkg::HMD_ST_RWAIT;
                        hready_ff <= 1'b0;
                        rd_idx_ff <= hit ? idx : 12'hfff;
                    end
                end
                hmd_pkg::HMD_ST_RWAIT: begin
                    // Load the answer and release the bus.
                    bus_st_ff <= hmd_pkg::HMD_ST_IDLE;
                    hready_ff <= 1'b1;
                    hrdata_ff <= rd_mux;
                end
            endcase
        end
    end

    // Response is always OKAY.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            hresp_ff <= 1'b0;
        end else begin
            hresp_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register.
    ////////////////////////////////////////////////////////////////////////
    // Chained mode bit, written by software.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            cont_ff <= 1'b0;
        end else if (wr_ctrl) begin
            cont_ff <= HWDATA_I[`HMD_CTRL_CONT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // 8/4 decoder: two bytes side by side.
    ////////////////////////////////////////////////////////////////////////
    // Each byte has its own decoder; result byte is {0,0,dbl,sgl,nibble}.
    for (genvar g = 0; g < 2; g++) begin : g_dec84
        logic [3:0] nib;
        hmd_dec84 u_dec (
            .code_i(HWDATA_I[8 * g +: 8]),
            .data_o(nib),
            .single_o(sgl84[g]),
            .double_o(dbl84[g])
        );
        assign nxt_res84[8 * g +: 8] = {2'h0, dbl84[g], sgl84[g], nib};
    end

    // The 8/4 result changes only on a standalone write and is held after.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            res84_ff <= `HMD_RST_WORD;
        end else if (do_84) begin
            res84_ff <= nxt_res84;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // 24/18 decoder and chained word assembly.
    ////////////////////////////////////////////////////////////////////////
    // A high write completes the first word; a chained 8/4 write completes
    // the next one from its high and middle bytes plus the saved low byte.
    assign in_2418 = wr_hi ? {HWDATA_I[7:0], coded_lo_ff}
                           : {HWDATA_I[15:8], HWDATA_I[7:0], l2_ff};

    hmd_dec2418 u_dec2418 (
        .code_i(in_2418),
        .data_o(d2418),
        .single_o(s2418),
        .double_o(b2418)
    );

    // Coded halves kept until the word is complete.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            coded_lo_ff <= `HMD_RST_WORD;
            l2_ff <= 8'h00;
        end else begin
            if (wr_lo) begin
                coded_lo_ff <= HWDATA_I[15:0];
            end
            if (wr_hi) begin
                l2_ff <= HWDATA_I[15:8];
            end
        end
    end

    // Results load the registers that software reads, apart from the coded data, and then hold.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            res_lo_ff <= `HMD_RST_WORD;
            res_hi_ff <= `HMD_RST_WORD;
        end else if (do_2418) begin
            res_lo_ff <= d2418[15:0];
            res_hi_ff <= {10'h000, b2418, s2418, 2'h0, d2418[17:16]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Events, status, mask and interrupt.
    ////////////////////////////////////////////////////////////////////////
    // Error and completion events of this cycle.
    always_comb begin
        ev = `HMD_RST_EV;
        ev[`HMD_EV_SGL] = (do_84 & (|sgl84)) | (do_2418 & s2418);
        ev[`HMD_EV_DBL] = (do_84 & (|dbl84)) | (do_2418 & b2418);
        ev[`HMD_EV_DONE] = do_84 | do_2418;
    end

    // Write one clears; a new event in the same cycle wins.
    always_comb begin
        nxt_stat = stat_ff;
        if (wr_stat) begin
            nxt_stat = stat_ff & ~HWDATA_I[2:0];
        end
        nxt_stat = nxt_stat | ev;
    end

    // Sticky status bits.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            stat_ff <= `HMD_RST_EV;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    // Mask register.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            mask_ff <= `HMD_RST_EV;
        end else if (wr_mask) begin
            mask_ff <= HWDATA_I[2:0];
        end
    end

    // Interrupt level follows any unmasked set bit.
    always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
        if (SYS_RST_I) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(stat_ff & mask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.
    ////////////////////////////////////////////////////////////////////////
    assign HRDATA_O = hrdata_ff;
    assign HREADYOUT_O = hready_ff;
    assign HRESP_O = hresp_ff;
    assign IRQ_O = irq_ff;

    ////////////////////////////////////////////////////////////////////////
    // Assertions and cover points.
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    // A read holds ready low exactly one cycle.
    rd_wait_a: assert property (
        (bus_st_ff == hmd_pkg::HMD_ST_IDLE) && acc && !HWRITE_I
        |=> !HREADYOUT_O ##1 HREADYOUT_O)
        else $error("read wait state wrong");

    // No 8/4 decode without its write.
    hold84_a: assert property (
        !do_84 |=> $stable(res84_ff))
        else $error("8/4 result changed without write");

    // Double error clears the data nibble.
    dbl84_a: assert property (
        do_84 && dbl84[0] |=> res84_ff[5] && (res84_ff[3:0] == 4'h0))
        else $error("8/4 double error left data");

    // Error flags never both set in 8/4 byte 0 or in the 24/18 high result.
    flags84_a: assert property (
        !(res84_ff[4] && res84_ff[5]) && !(res_hi_ff[4] && res_hi_ff[5]))
        else $error("single and double both set");

    // 24/18 results hold without a completing write.
    hold2418_a: assert property (
        !do_2418 |=> $stable(res_lo_ff) && $stable(res_hi_ff))
        else $error("24/18 result changed without write");

    // Chained 8/4 write leaves the 8/4 result alone.
    chain84_a: assert property (
        wr_84 && cont_ff |=> $stable(res84_ff) && stat_ff[2])
        else $error("chained write disturbed 8/4 result");

    // High write saves the next word's low byte.
    chain_l2_a: assert property (
        wr_hi |=> l2_ff == $past(HWDATA_I[15:8]))
        else $error("low byte of next word not saved");

    // Read of the low result returns that result.
    rd_lo_a: assert property (
        (bus_st_ff == hmd_pkg::HMD_ST_IDLE) && acc && !HWRITE_I && hit
        && (idx == `HMD_IDX_LO)
        |=> ##1 HRDATA_O == {16'h0000, $past(res_lo_ff)})
        else $error("24/18 low read data wrong");

    // Interrupt follows status and mask.
    irq_lvl_a: assert property (
        (|(stat_ff & mask_ff)) |=> IRQ_O)
        else $error("interrupt not raised");

    // Main scenarios.
    chain_c: cover property (wr_hi ##[1:20] (wr_84 && cont_ff));
    dbl_c: cover property (do_2418 && b2418);
    sgl_c: cover property (do_84 && sgl84[0] && sgl84[1]);
    rd_c: cover property (acc && !HWRITE_I ##2 HREADYOUT_O);
endmodule : hmd_top

/* testbench/hmd_top_tb.sv */
// Self-checking bench for the Hamming decoder pair, driven over AHB-Lite.
`include "hmd_params.svh"
module hmd_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////////
    // Byte addresses are four times each register index.
    localparam logic [31:0] A_H84 = {18'h0, `HMD_IDX_H84, 2'b00};
    localparam logic [31:0] A_LO = {18'h0, `HMD_IDX_LO, 2'b00};
    localparam logic [31:0] A_HI = {18'h0, `HMD_IDX_HI, 2'b00};
    localparam logic [31:0] A_CTRL = {18'h0, `HMD_IDX_CTRL, 2'b00};
    localparam logic [31:0] A_STAT = {18'h0, `HMD_IDX_STAT, 2'b00};
    localparam logic [31:0] A_MASK = {18'h0, `HMD_IDX_MASK, 2'b00};
    localparam logic [31:0] A_NONE = 32'h0000_0890;
    // Data words for the 24/18 tests, including the all-ones corner.
    localparam logic [17:0] DTAB [4] = '{18'h00000, 18'h3ffff, 18'h2a5c3, 18'h15a3c};
    // Cycle ceiling: about 134 accesses of three or four cycles, some 500 in all, with wide margin.
    localparam int LIMIT = 5000;
    logic clk, rst, hsel, hwrite, hreadyout, hresp, irq;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rdata;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////////////////
    // The single slave drives the bus ready itself.
    hmd_top i_dut (.CLK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
        .HREADY_I(hreadyout), .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout),
        .HRESP_O(hresp), .IRQ_O(irq));
    // Free-running 125 MHz clock.
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Cuts a hang short and counts it as a mismatch.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t: timeout", $time);
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Compares one value with its expectation and counts the result.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk
    // One single transfer: address phase held until ready, then the data phase.
    task automatic ahb_xfer(input logic [31:0] a, input logic wr, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdata = hrdata;
        chk({31'h0, hresp}, 32'h0000_0000, "response");
    endtask : ahb_xfer
    task automatic ahb_write(input logic [31:0] a, input logic [31:0] d);
        ahb_xfer(a, 1'b1, d);
    endtask : ahb_write
    // Reads one register and compares it.
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        ahb_xfer(a, 1'b0, 32'h0000_0000);
        chk(rdata, exp, "read");
    endtask : rd_chk
    // Waits out the interrupt lag, then compares the line.
    task automatic irq_chk(input logic exp);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, {31'h0, exp}, "interrupt");
    endtask : irq_chk
    task automatic done_test(input string nm);
        $display("Test %s finished", nm);
    endtask : done_test
    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////
    // Builds a clean 8/4 byte: data on odd bits, odd parity in every check group.
    function automatic logic [7:0] enc84(input logic [3:0] n);
        logic [7:0] c;
        c = {n[3], 1'b0, n[2], 1'b0, n[1], 1'b0, n[0], 1'b0};
        c[0] = ~(c[1] ^ c[5] ^ c[7]);
        c[2] = ~(c[1] ^ c[3] ^ c[7]);
        c[4] = ~(c[1] ^ c[3] ^ c[5]);
        c[6] = ~(^{c[7], c[5:0]});
        return c;
    endfunction : enc84
    // Builds a clean 24/18 word: zero syndrome, odd parity over all 24 bits.
    function automatic logic [23:0] enc24(input logic [17:0] d);
        logic [23:0] c;
        int k;
        int s;
        c = '0;
        k = 0;
        s = 0;
        for (int p = 1; p < 24; p++) begin
            if ((p & (p - 1)) != 0) begin
                c[p-1] = d[k];
                k++;
                if (d[k-1]) s = s ^ p;
            end
        end
        for (int j = 0; j < 5; j++) c[(1 << j) - 1] = s[j];
        c[23] = ~(^c[22:0]);
        return c;
    endfunction : enc24
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence of tests.
    initial begin
        logic [23:0] cw, cw2;
        logic [17:0] dv;
        logic sg, db;
        rst = 1'b1;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = '0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // Every register reads zero; an unmapped place ignores writes.
        rd_chk(A_H84, 32'h0);
        rd_chk(A_LO, 32'h0);
        rd_chk(A_HI, 32'h0);
        rd_chk(A_CTRL, 32'h0);
        rd_chk(A_STAT, 32'h0);
        rd_chk(A_MASK, 32'h0);
        ahb_write(A_NONE, 32'hffff_ffff);
        rd_chk(A_NONE, 32'h0);
        done_test("reset");
        // Byte 0 clean, byte 1 with a single error, every nibble value.
        for (int i = 0; i < 16; i++) begin
            ahb_write(A_H84, {16'h0, enc84(4'(15 - i)) ^ 8'(1 << (i % 8)), enc84(4'(i))});
            rd_chk(A_H84, {18'h0, 2'b01, 4'(15 - i), 4'h0, 4'(i)});
        end
        // Double errors on byte 0 give flags only.
        for (int i = 0; i < 8; i++) begin
            ahb_write(A_H84, {16'h0, enc84(4'h9), enc84(4'(i)) ^ 8'(3 << i % 7)});
            rd_chk(A_H84, {18'h0, 2'b00, 4'h9, 4'h2, 4'h0});
        end
        rd_chk(A_H84, {18'h0, 2'b00, 4'h9, 4'h2, 4'h0});
        done_test("decode_8_4");
        // 24/18 words: clean, single error, double error.
        for (int i = 0; i < 12; i++) begin
            dv = DTAB[i % 4];
            cw = enc24(dv);
            sg = (i / 4 == 1);
            db = (i / 4 == 2);
            if (sg) cw[i+2] = ~cw[i+2];
            if (db) cw = cw ^ (24'h3 << i);
            ahb_write(A_LO, {16'h0, cw[15:0]});
            ahb_write(A_HI, {24'h0, cw[23:16]});
            rd_chk(A_LO, db ? 32'h0 : {16'h0, dv[15:0]});
            rd_chk(A_HI, {26'h0, db, sg, 2'b00, db ? 2'b00 : dv[17:16]});
        end
        // A low write alone starts no decode; the old result stays.
        ahb_write(A_LO, 32'h0000_1234);
        rd_chk(A_HI, 32'h0000_0020);
        done_test("decode_24_18");
        // Chained decoding, two rounds of two words each.
        ahb_write(A_CTRL, 32'h1);
        for (int j = 0; j < 2; j++) begin
            cw = enc24(DTAB[2 * j]);
            cw2 = enc24(DTAB[2 * j + 1]);
            cw2[10 + j] = ~cw2[10 + j];
            ahb_write(A_LO, {16'h0, cw[15:0]});
            ahb_write(A_HI, {16'h0, cw2[7:0], cw[23:16]});
            rd_chk(A_LO, {16'h0, DTAB[2 * j][15:0]});
            rd_chk(A_HI, {30'h0, DTAB[2 * j][17:16]});
            ahb_write(A_H84, {16'h0, cw2[23:8]});
            rd_chk(A_LO, {16'h0, DTAB[2 * j + 1][15:0]});
            rd_chk(A_HI, {26'h0, 2'b01, 2'b00, DTAB[2 * j + 1][17:16]});
        end
        // The 8/4 result is untouched by chained writes.
        rd_chk(A_H84, {18'h0, 2'b00, 4'h9, 4'h2, 4'h0});
        ahb_write(A_CTRL, 32'h0);
        done_test("chained");
        // Sticky status, mask and the interrupt line.
        ahb_write(A_STAT, 32'h7);
        rd_chk(A_STAT, 32'h0);
        ahb_write(A_H84, {16'h0, enc84(4'h1), enc84(4'h5) ^ 8'h81});
        rd_chk(A_STAT, 32'h6);
        irq_chk(1'b0);
        ahb_write(A_MASK, 32'h2);
        irq_chk(1'b1);
        ahb_write(A_STAT, 32'h2);
        rd_chk(A_STAT, 32'h4);
        irq_chk(1'b0);
        ahb_write(A_MASK, 32'h7);
        irq_chk(1'b1);
        ahb_write(A_STAT, 32'h4);
        irq_chk(1'b0);
        rd_chk(A_MASK, 32'h7);
        done_test("interrupt");
        finish_test();
    end
endmodule : hmd_top_tb
